// ### inc/exception_priority_entry_regs.svh
/*
 * Offsets, field positions, reset values and fixed codes of the exception
 * priority and entry block.
 * Assumes byte addressing on an 8-bit register port with one word per register.
 */
`ifndef EXCEPTION_PRIORITY_ENTRY_REGS_SVH
`define EXCEPTION_PRIORITY_ENTRY_REGS_SVH

// ==========================================================================
// Exception numbering
`define NUM_EXC 24
`define IMPL_MASK 24'hffc87c
`define EXC_NMI 5'h02
`define EXC_HARD 5'h03
`define EXC_FIRST_CFG 5'h04

// ==========================================================================
// Register offsets
`define REG_PRIO_BASE 8'h00
`define REG_PRIO_END 8'h60
`define REG_CTRL 8'h80
`define REG_MASK 8'h84
`define REG_PEND 8'h88
`define REG_ACTIVE 8'h8c
`define REG_STATUS 8'h90

// ==========================================================================
// Fields and reset values
`define CTRL_ALIGN_BIT 8
`define MASK_PRIMASK_BIT 8
`define PRIO_RST 4'h0
`define SPLIT_RST 3'h0
`define ALIGN_RST 1'b1
`define MAX_SUB_BITS 3'h4

// ==========================================================================
// Ranking, frames and return codes
`define CLS_NMI 2'h1
`define CLS_HARD 2'h2
`define CLS_CFG 2'h3
`define LVL_NONE 7'h7f
`define FRAME_BASIC 5'h08
`define FRAME_FP 5'h1a
`define PSR_PAD_BIT 9
`define RET_UPPER 27'h7ffffff
`define RET_LOW 2'h1
`define VEC_BASE 32'h00000000

`endif

// ### inc/exc_entry_pkg.sv
/*
 * Types shared by the exception priority and entry block.
 * Assumes the core supplies its context as one packed bundle.
 */
package exc_entry_pkg;

	// ======================================================================
	// Types
	typedef enum logic [2:0] {ST_RUN, ST_STACK, ST_LAUNCH, ST_CHECK, ST_UNSTACK} entry_state_e;

	typedef struct packed {
		logic [31:0] r0;
		logic [31:0] r1;
		logic [31:0] r2;
		logic [31:0] r3;
		logic [31:0] r12;
		logic [31:0] link_ret;
		logic [31:0] ret_pc;
		logic [31:0] psr;
	} ctx_s;

	typedef logic [6:0] rank_t;

endpackage : exc_entry_pkg

// ### core/exception_priority_entry.sv
/*
 * Exception priority resolution, stacking, vector fetch, late arrival,
 * tail-chaining and unstacking for a small processor core.
 * Assumes the core holds ctx, fp_state, msp and psp stable while a frame is
 * stacked, and that memory and vector reads answer in the next cycle.
 */
// Our own choices: the address-and-strobe port and the address map.
`timescale 1ns/10ps
`include "exception_priority_entry_regs.svh"

// Contract
// - Smaller priority value is more urgent
// - Fixed negative levels outrank configurable ones
// - Configurable priorities reset to zero
// - Configurable priorities hold sixteen values
// - Equal priority: lowest exception number first
// - Only strictly more urgent preempts
// - Priority split into group and subpriority
// - Preemption compares group field only
// - Subpriority then lowest number orders service
// - Nothing qualifies on completion: unstack
// - Qualifying pending on completion: tail-chain
// - Late arrival redirects vector, stacking continues
// - Late arrival closes at first execute
// - Entry in thread mode or outranking
// - Masked exceptions stay pending
// - Push eight-word frame on current stack
// - Extended frame when floating point active
// - Stack pointer ends at frame bottom
// - Frame holds return address
// - Vector fetch parallel; start after stacking
// - Link register gets return code
// - Pending becomes active as handler begins
// - Return code upper bits all ones
module exception_priority_entry
	import exc_entry_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic [15:0] sys_req,
	input wire logic [7:0] irq_pin,
	input wire ctx_s ctx,
	input wire logic [16:0][31:0] fp_state,
	input wire logic fp_active,
	input wire logic [31:0] msp,
	input wire logic [31:0] psp,
	input wire logic psp_sel,
	input wire logic handler_done,
	input wire logic [31:0] done_code,
	input wire logic first_exec,
	output logic handler_start,
	output logic [31:0] handler_pc,
	output logic [31:0] link_register,
	output logic [4:0] cur_exc,
	output logic sp_load,
	output logic sp_load_psp,
	output logic [31:0] sp_value,
	output logic resume,
	output logic vec_rd,
	output logic [31:0] vec_addr,
	input wire logic [31:0] vec_data,
	output logic mem_wr,
	output logic mem_rd,
	output logic [31:0] mem_addr,
	output logic [31:0] mem_wdata,
	input wire logic [31:0] mem_rdata,
	output logic restore_valid,
	output logic [4:0] restore_idx,
	output logic [31:0] restore_data
);

	localparam logic [23:0] IMPL = `IMPL_MASK;

	logic [3:0] prio_reg [`NUM_EXC];
	logic [2:0] split_reg;
	logic align_reg;
	logic [3:0] basepri_reg;
	logic primask_reg;
	logic [23:0] pend_reg;
	logic [23:0] active_reg;
	entry_state_e state_reg;
	logic [4:0] target_reg;
	logic [4:0] cnt_reg;
	logic [4:0] words_reg;
	logic [31:0] base_reg;
	logic [31:0] code_reg;
	logic pad_reg;
	logic vec_wait_reg;
	logic vec_got_reg;
	logic [31:0] vec_pc_reg;
	logic started_reg;
	logic rdq_reg;
	logic [4:0] rdq_idx_reg;
	logic [7:0] irq_meta_reg;
	logic [7:0] irq_sync_reg;
	logic [7:0] irq_last_reg;

	// ======================================================================
	// Ranking
	// A fixed exception ranks by class alone, so no programmed value can
	// ever reach it.
	function automatic rank_t rank(input logic [4:0] n, input logic [3:0] p,
		input logic [3:0] m);
		if (n == `EXC_NMI)
			rank = {1'b0, `CLS_NMI, 4'h0};
		else if (n == `EXC_HARD)
			rank = {1'b0, `CLS_HARD, 4'h0};
		else
			rank = {1'b0, `CLS_CFG, p & m};
	endfunction : rank

	logic [3:0] gmask;
	logic found;
	logic [4:0] best;
	rank_t best_key;
	rank_t lvl;
	rank_t mlvl;
	logic [4:0] inner;
	logic take;
	logic late;

	assign gmask = 4'hf << ((split_reg > `MAX_SUB_BITS) ? `MAX_SUB_BITS : split_reg);

	always_comb begin
		found = 1'b0;
		best = 5'h00;
		best_key = `LVL_NONE;
		lvl = `LVL_NONE;
		inner = 5'h00;
		for (int i = 0; i < `NUM_EXC; i++) begin
			// Strict compare in ascending order keeps the lowest number on a tie.
			if (pend_reg[i] && rank(5'(i), prio_reg[i], 4'hf) < best_key) begin
				found = 1'b1;
				best = 5'(i);
				best_key = rank(5'(i), prio_reg[i], 4'hf);
			end
			if (active_reg[i] && rank(5'(i), prio_reg[i], gmask) < lvl) begin
				lvl = rank(5'(i), prio_reg[i], gmask);
				inner = 5'(i);
			end
		end
		mlvl = lvl;
		if (primask_reg && {1'b0, `CLS_CFG, 4'h0} < mlvl)
			mlvl = {1'b0, `CLS_CFG, 4'h0};
		if (basepri_reg != 4'h0 && {1'b0, `CLS_CFG, basepri_reg & gmask} < mlvl)
			mlvl = {1'b0, `CLS_CFG, basepri_reg & gmask};
	end

	// Thread mode has no active level, so any sufficient exception enters.
	assign take = found && (rank(best, prio_reg[best], gmask) < mlvl);
	assign late = take && (rank(best, prio_reg[best], gmask) <
		rank(target_reg, prio_reg[target_reg], gmask));

	// ======================================================================
	// Entry frame arithmetic
	logic thread;
	logic use_psp;
	logic [31:0] sp_cur;
	logic [4:0] words_n;
	logic [31:0] raw;
	logic [31:0] base_n;
	logic [31:0] code_n;
	logic [31:0] frame_word;

	assign thread = (active_reg == 24'h000000);
	assign use_psp = thread & psp_sel;
	assign sp_cur = use_psp ? psp : msp;
	assign words_n = fp_active ? `FRAME_FP : `FRAME_BASIC;
	assign raw = sp_cur - {25'h0000000, words_n, 2'h0};
	assign base_n = align_reg ? {raw[31:3], 3'h0} : raw;
	assign code_n = {`RET_UPPER, ~fp_active, thread, use_psp, `RET_LOW};

	always_comb begin
		case (cnt_reg)
			5'h00: frame_word = ctx.r0;
			5'h01: frame_word = ctx.r1;
			5'h02: frame_word = ctx.r2;
			5'h03: frame_word = ctx.r3;
			5'h04: frame_word = ctx.r12;
			5'h05: frame_word = ctx.link_ret;
			5'h06: frame_word = ctx.ret_pc;
			5'h07: frame_word = {ctx.psr[31:10], pad_reg, ctx.psr[8:0]};
			5'h19: frame_word = 32'h00000000;
			default: frame_word = fp_state[5'(cnt_reg - 5'h08)];
		endcase
	end

	// ======================================================================
	// Pin synchroniser
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			irq_meta_reg <= 8'h00;
			irq_sync_reg <= 8'h00;
			irq_last_reg <= 8'h00;
		end else begin
			irq_meta_reg <= irq_pin;
			irq_sync_reg <= irq_meta_reg;
			irq_last_reg <= irq_sync_reg;
		end
	end

	// ======================================================================
	// Pending and active status
	logic [23:0] pend_set;
	logic commit;
	logic done_now;

	assign commit = (state_reg == ST_LAUNCH) && started_reg && first_exec;
	assign done_now = (state_reg == ST_RUN) && handler_done && !thread;
	assign pend_set = IMPL & ({irq_sync_reg & ~irq_last_reg, sys_req} |
		((reg_wr && reg_addr == `REG_PEND) ? reg_wdata[23:0] : 24'h000000));

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pend_reg <= 24'h000000;
			active_reg <= 24'h000000;
		end else begin
			// A new request in the clearing cycle stays pending.
			pend_reg <= (pend_reg & ~((commit ? 24'h000001 : 24'h000000) << target_reg))
				| pend_set;
			active_reg <= (active_reg & ~((done_now ? 24'h000001 : 24'h000000) << inner))
				| ((commit ? 24'h000001 : 24'h000000) << target_reg);
		end
	end

	// ======================================================================
	// Entry, late arrival, tail-chain and return sequencer
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_reg <= ST_RUN;
			target_reg <= 5'h00;
			cnt_reg <= 5'h00;
			words_reg <= `FRAME_BASIC;
			base_reg <= 32'h00000000;
			code_reg <= 32'h00000000;
			pad_reg <= 1'b0;
			started_reg <= 1'b0;
			vec_rd <= 1'b0;
			vec_addr <= `VEC_BASE;
			handler_start <= 1'b0;
			handler_pc <= 32'h00000000;
			link_register <= 32'h00000000;
			sp_load <= 1'b0;
			sp_load_psp <= 1'b0;
			sp_value <= 32'h00000000;
			resume <= 1'b0;
		end else begin
			vec_rd <= 1'b0;
			handler_start <= 1'b0;
			sp_load <= 1'b0;
			resume <= 1'b0;
			case (state_reg)
				ST_RUN: begin
					if (done_now) begin
						code_reg <= done_code;
						state_reg <= ST_CHECK;
					end else if (take) begin
						state_reg <= ST_STACK;
						target_reg <= best;
						cnt_reg <= 5'h00;
						words_reg <= words_n;
						base_reg <= base_n;
						pad_reg <= align_reg & raw[2];
						code_reg <= code_n;
						started_reg <= 1'b0;
						vec_rd <= 1'b1;
						vec_addr <= `VEC_BASE + {25'h0000000, best, 2'h0};
					end
				end
				ST_STACK: begin
					cnt_reg <= cnt_reg + 5'h01;
					if (cnt_reg == words_reg - 5'h01) begin
						state_reg <= ST_LAUNCH;
						sp_load <= 1'b1;
						sp_load_psp <= code_reg[2];
						sp_value <= base_reg;
					end
					if (late) begin
						target_reg <= best;
						vec_rd <= 1'b1;
						vec_addr <= `VEC_BASE + {25'h0000000, best, 2'h0};
					end
				end
				ST_LAUNCH: begin
					if (commit) begin
						state_reg <= ST_RUN;
					end else if (late) begin
						target_reg <= best;
						started_reg <= 1'b0;
						vec_rd <= 1'b1;
						vec_addr <= `VEC_BASE + {25'h0000000, best, 2'h0};
					end else if (vec_got_reg && !vec_wait_reg && !vec_rd && !started_reg) begin
						handler_start <= 1'b1;
						handler_pc <= vec_pc_reg;
						link_register <= code_reg;
						started_reg <= 1'b1;
					end
				end
				ST_CHECK: begin
					if (take) begin
						state_reg <= ST_LAUNCH;
						target_reg <= best;
						started_reg <= 1'b0;
						vec_rd <= 1'b1;
						vec_addr <= `VEC_BASE + {25'h0000000, best, 2'h0};
					end else begin
						state_reg <= ST_UNSTACK;
						cnt_reg <= 5'h00;
						words_reg <= code_reg[4] ? `FRAME_BASIC : `FRAME_FP;
						base_reg <= code_reg[2] ? psp : msp;
						pad_reg <= 1'b0;
					end
				end
				ST_UNSTACK: begin
					if (cnt_reg != words_reg)
						cnt_reg <= cnt_reg + 5'h01;
					if (rdq_reg && rdq_idx_reg == 5'h07)
						pad_reg <= mem_rdata[`PSR_PAD_BIT];
					if (rdq_reg && rdq_idx_reg == words_reg - 5'h01) begin
						state_reg <= ST_RUN;
						resume <= 1'b1;
						sp_load <= 1'b1;
						sp_load_psp <= code_reg[2];
						sp_value <= base_reg + {25'h0000000, words_reg, 2'h0} +
							{29'h00000000, (rdq_idx_reg == 5'h07) ? mem_rdata[`PSR_PAD_BIT] : pad_reg,
							2'h0};
					end
				end
				default: state_reg <= ST_RUN;
			endcase
		end
	end

	// ======================================================================
	// Vector fetch capture
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			vec_wait_reg <= 1'b0;
			vec_got_reg <= 1'b0;
			vec_pc_reg <= 32'h00000000;
		end else begin
			vec_wait_reg <= vec_rd;
			if (vec_rd)
				vec_got_reg <= 1'b0;
			else if (vec_wait_reg) begin
				vec_got_reg <= 1'b1;
				vec_pc_reg <= vec_data;
			end
		end
	end

	// ======================================================================
	// Stack memory port
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			mem_wr <= 1'b0;
			mem_rd <= 1'b0;
			mem_addr <= 32'h00000000;
			mem_wdata <= 32'h00000000;
			rdq_reg <= 1'b0;
			rdq_idx_reg <= 5'h00;
			restore_valid <= 1'b0;
			restore_idx <= 5'h00;
			restore_data <= 32'h00000000;
		end else begin
			// Stacking is never cut short by a late arrival, the frame is shared.
			mem_wr <= (state_reg == ST_STACK);
			mem_rd <= (state_reg == ST_UNSTACK) && (cnt_reg != words_reg);
			mem_addr <= base_reg + {25'h0000000, cnt_reg, 2'h0};
			mem_wdata <= frame_word;
			rdq_reg <= mem_rd;
			rdq_idx_reg <= 5'(mem_addr[6:2] - base_reg[6:2]);
			restore_valid <= rdq_reg;
			restore_idx <= rdq_idx_reg;
			restore_data <= mem_rdata;
		end
	end

	// ======================================================================
	// Register port
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			for (int i = 0; i < `NUM_EXC; i++)
				prio_reg[i] <= `PRIO_RST;
			split_reg <= `SPLIT_RST;
			align_reg <= `ALIGN_RST;
			basepri_reg <= 4'h0;
			primask_reg <= 1'b0;
		end else if (reg_wr) begin
			if (reg_addr < `REG_PRIO_END && reg_addr[1:0] == 2'h0 &&
				reg_addr[6:2] >= `EXC_FIRST_CFG && IMPL[reg_addr[6:2]])
				prio_reg[reg_addr[6:2]] <= reg_wdata[3:0];
			if (reg_addr == `REG_CTRL) begin
				split_reg <= reg_wdata[2:0];
				align_reg <= reg_wdata[`CTRL_ALIGN_BIT];
			end
			if (reg_addr == `REG_MASK) begin
				basepri_reg <= reg_wdata[3:0];
				primask_reg <= reg_wdata[`MASK_PRIMASK_BIT];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			reg_rdata <= 32'h00000000;
			cur_exc <= 5'h00;
		end else begin
			cur_exc <= inner;
			reg_rdata <= 32'h00000000;
			if (reg_rd) begin
				if (reg_addr < `REG_PRIO_END && reg_addr[1:0] == 2'h0)
					reg_rdata <= {28'h0000000, prio_reg[reg_addr[6:2]]};
				else
					case (reg_addr)
						`REG_CTRL: reg_rdata <= {23'h000000, align_reg, 5'h00, split_reg};
						`REG_MASK: reg_rdata <= {23'h000000, primask_reg, 4'h0, basepri_reg};
						`REG_PEND: reg_rdata <= {8'h00, pend_reg};
						`REG_ACTIVE: reg_rdata <= {8'h00, active_reg};
						`REG_STATUS: reg_rdata <= {19'h00000, state_reg, target_reg, cur_exc};
						default: reg_rdata <= 32'h00000000;
					endcase
			end
		end
	end

	// ======================================================================
	// Checks
	AST_PRIO_RESET: assert property (@(posedge clk) $past(!rst_n) |-> prio_reg[5] == 4'h0)
		else $error("Priority not zero after reset.");
	AST_PRIO_WIDTH: assert property (@(posedge clk) disable iff (!rst_n)
		$past(reg_rd) && $past(reg_addr) == `REG_PRIO_BASE + 8'h10 |-> reg_rdata[31:4] == 28'h0)
		else $error("Priority field wider than four bits.");
	AST_MASKED: assert property (@(posedge clk) disable iff (!rst_n)
		state_reg == ST_RUN && primask_reg && !done_now && best > `EXC_HARD && pend_reg == (24'h1 << best)
		|=> state_reg != ST_STACK)
		else $error("Masked exception taken.");
	AST_FRAME_BASIC: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(mem_wr) && words_reg == `FRAME_BASIC |-> mem_wr [*8] ##1 !mem_wr)
		else $error("Basic frame is not eight words.");
	AST_LR_UPPER: assert property (@(posedge clk) disable iff (!rst_n)
		handler_start |-> link_register[31:5] == `RET_UPPER)
		else $error("Return code upper bits not all ones.");
	AST_START_AFTER: assert property (@(posedge clk) disable iff (!rst_n)
		handler_start |-> !mem_wr && state_reg == ST_LAUNCH && $past(state_reg) != ST_STACK)
		else $error("Handler started before stacking ended.");
	AST_SP_BOTTOM: assert property (@(posedge clk) disable iff (!rst_n)
		state_reg == ST_LAUNCH && $past(state_reg) == ST_STACK
		|-> sp_load && sp_value == base_reg && (!align_reg || sp_value[2:0] == 3'h0))
		else $error("Stack pointer not at frame bottom.");
	AST_ACTIVATE: assert property (@(posedge clk) disable iff (!rst_n)
		commit |=> active_reg[$past(target_reg)] && state_reg == ST_RUN)
		else $error("Serviced exception not made active.");
	AST_TAIL: assert property (@(posedge clk) disable iff (!rst_n)
		state_reg == ST_CHECK && take |=> state_reg == ST_LAUNCH && vec_rd ##1 !mem_wr)
		else $error("Tail-chain did not skip unstacking.");

endmodule : exception_priority_entry

// ### bench/core_mem_model.sv
/*
 * Model of the core pipeline, the stack memory and the vector table.
 * Assumes it shares the block's clock and that every answer comes one cycle late.
 */
`timescale 1ns/10ps
module core_mem_model (
	input wire logic clk,
	input wire logic [2:0] exec_delay,
	input wire logic handler_start,
	output logic first_exec,
	input wire logic vec_rd,
	input wire logic [31:0] vec_addr,
	output logic [31:0] vec_data,
	input wire logic mem_wr,
	input wire logic mem_rd,
	input wire logic [31:0] mem_addr,
	input wire logic [31:0] mem_wdata,
	output logic [31:0] mem_rdata
);
	// ==============================
	// Behaviour
	// Idle read lines toggle, so a sample taken a cycle late never sees the old answer.
	logic [31:0] mem [0:255];
	logic [2:0] cnt;
	initial begin
		vec_data = 32'h0;
		mem_rdata = 32'h0;
		first_exec = 1'b0;
		cnt = 3'h0;
	end
	always @(posedge clk) begin
		vec_data <= vec_rd ? 32'h08000001 + (vec_addr << 4) : ~vec_data;
		mem_rdata <= mem_rd ? mem[mem_addr[9:2]] : ~mem_rdata;
		if (mem_wr) begin
			mem[mem_addr[9:2]] <= mem_wdata;
		end
		first_exec <= (cnt == 3'h1);
		if (handler_start) begin
			cnt <= exec_delay;
		end else if (cnt != 3'h0) begin
			cnt <= cnt - 3'h1;
		end
	end
endmodule : core_mem_model

// ### bench/tb.sv
/*
 * Self-checking bench for the exception priority and entry block.
 * Assumes core_mem_model stands in for the pipeline and the stack memory.
 */
`timescale 1ns/10ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fail_count++; \
	$display("[FAIL] %0t got %h want %h", $time, (a), (b)); end end
module tb;
	// ==============================
	// Signals
	logic clk, rst_n, reg_wr, reg_rd, fp_active, psp_sel, handler_done, first_exec;
	logic handler_start, sp_load, sp_load_psp, resume, vec_rd, mem_wr, mem_rd, restore_valid;
	logic [7:0] reg_addr, irq_pin;
	logic [15:0] sys_req;
	logic [2:0] exec_delay;
	logic [4:0] cur_exc, restore_idx;
	logic [31:0] reg_wdata, reg_rdata, msp, psp, done_code, handler_pc, link_register;
	logic [31:0] sp_value, vec_addr, vec_data, mem_addr, mem_wdata, mem_rdata, restore_data;
	logic [31:0] last_sp;
	logic [31:0] w [8];
	logic [16:0][31:0] fp_state;
	exc_entry_pkg::ctx_s ctx;
	int fail_count, n_checks, wcnt, rcnt, mrdc;

	exception_priority_entry exception_priority_entry_i (.clk, .rst_n, .reg_addr, .reg_wdata,
		.reg_wr, .reg_rd, .reg_rdata, .sys_req, .irq_pin, .ctx, .fp_state, .fp_active, .msp,
		.psp, .psp_sel, .handler_done, .done_code, .first_exec, .handler_start, .handler_pc,
		.link_register, .cur_exc, .sp_load, .sp_load_psp, .sp_value, .resume, .vec_rd,
		.vec_addr, .vec_data, .mem_wr, .mem_rd, .mem_addr, .mem_wdata, .mem_rdata,
		.restore_valid, .restore_idx, .restore_data);
	core_mem_model core_mem_model_i (.clk, .exec_delay, .handler_start, .first_exec, .vec_rd,
		.vec_addr, .vec_data, .mem_wr, .mem_rd, .mem_addr, .mem_wdata, .mem_rdata);

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	always @(posedge clk) begin
		if (mem_wr) wcnt <= wcnt + 1;
		if (mem_rd) mrdc <= mrdc + 1;
		if (restore_valid) rcnt <= rcnt + 1;
		if (sp_load) last_sp <= sp_value;
		// The core takes every new stack pointer, so a return unstacks where its frame is.
		if (sp_load && sp_load_psp) psp <= sp_value;
		if (sp_load && !sp_load_psp) msp <= sp_value;
		if (restore_valid && restore_idx < 5'h08)
			`CHK(restore_data & 32'hfffffdff, w[restore_idx[2:0]] & 32'hfffffdff)
		if (restore_valid && restore_idx >= 5'h08 && restore_idx < 5'h19)
			`CHK(restore_data, fp_state[restore_idx - 5'h08])
		if (restore_valid && restore_idx == 5'h19)
			`CHK(restore_data, 32'h0)
	end

	// ==============================
	// Helpers
	task automatic conclude();
		$display("checks %0d fails %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : conclude
	task automatic expire(input logic ok);
		if (ok !== 1'b1) begin
			fail_count++;
			$display("[FAIL] %0t wait ran out", $time);
			conclude();
		end
	endtask : expire
	// Counters are cleared only while the block is idle, so no count is lost.
	task automatic clr();
		wcnt = 0;
		rcnt = 0;
		mrdc = 0;
	endtask : clr
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		@(posedge clk);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(posedge clk);
		`CHK(reg_rdata, e)
	endtask : rd
	// Waits long enough afterwards for the slowest first_exec to land.
	task automatic start(input int n);
		int i;
		for (i = 0; i < 60 && handler_start !== 1'b1; i++) @(posedge clk);
		expire(handler_start);
		`CHK(handler_pc, 32'h08000001 + n * 64)
		repeat (8) @(posedge clk);
	endtask : start
	task automatic done(input logic [31:0] code);
		handler_done <= 1'b1;
		done_code <= code;
		@(posedge clk);
		handler_done <= 1'b0;
	endtask : done
	task automatic wait_resume();
		int i;
		for (i = 0; i < 90 && resume !== 1'b1; i++) @(posedge clk);
		expire(resume);
		@(posedge clk);
	endtask : wait_resume

	// ==============================
	// Scenarios
	task automatic t_regs();
		rd(8'h10, 32'h0);
		rd(8'h5c, 32'h0);
		rd(8'h80, 32'h100);
		wr(8'h10, 32'h1f);
		rd(8'h10, 32'hf);
		wr(8'h08, 32'h5);
		rd(8'h08, 32'h0);
		rd(8'hf0, 32'h0);
	endtask : t_regs
	task automatic t_basic();
		int i;
		clr();
		wr(8'h88, 32'h800);
		start(11);
		`CHK(link_register, 32'hfffffff9)
		`CHK(wcnt, 8)
		`CHK(last_sp, 32'h1e0)
		for (i = 0; i < 8; i++) `CHK(core_mem_model_i.mem[8'h78 + i], w[i])
		rd(8'h8c, 32'h800);
		rd(8'h88, 32'h0);
		done(32'hfffffff9);
		wait_resume();
		`CHK(rcnt, 8)
		`CHK(last_sp, 32'h204)
	endtask : t_basic
	task automatic t_order();
		clr();
		wr(8'h10, 32'h2);
		wr(8'h88, 32'h74);
		start(2);
		done(32'hfffffff9);
		start(5);
		done(32'hfffffff9);
		start(6);
		done(32'hfffffff9);
		start(4);
		`CHK(mrdc, 0)
		done(32'hfffffff9);
		wait_resume();
	endtask : t_order
	task automatic t_group();
		wr(8'h80, 32'h102);
		wr(8'h40, 32'h9);
		wr(8'h44, 32'h8);
		wr(8'h48, 32'h4);
		wr(8'h88, 32'h30000);
		start(17);
		done(32'hfffffff9);
		start(16);
		clr();
		wr(8'h88, 32'h20000);
		repeat (30) @(posedge clk);
		`CHK(cur_exc, 5'h10)
		irq_pin <= 8'h04;
		start(18);
		`CHK(wcnt, 8)
		`CHK(link_register, 32'hfffffff1)
		done(32'hfffffff1);
		wait_resume();
		done(32'hfffffff9);
		start(17);
		done(32'hfffffff9);
		wait_resume();
		irq_pin <= 8'h00;
		wr(8'h80, 32'h100);
	endtask : t_group
	task automatic t_mask();
		wr(8'h84, 32'h100);
		wr(8'h88, 32'h10);
		repeat (20) @(posedge clk);
		rd(8'h8c, 32'h0);
		wr(8'h84, 32'h3);
		start(4);
		done(32'hfffffff9);
		wait_resume();
		wr(8'h84, 32'h2);
		wr(8'h88, 32'h10);
		repeat (20) @(posedge clk);
		rd(8'h88, 32'h10);
		wr(8'h84, 32'h0);
		start(4);
		done(32'hfffffff9);
		wait_resume();
	endtask : t_mask
	task automatic t_late();
		fp_active <= 1'b1;
		psp_sel <= 1'b1;
		exec_delay <= 3'h5;
		clr();
		wr(8'h88, 32'h10);
		repeat (3) @(posedge clk);
		sys_req <= 16'h0040;
		@(posedge clk);
		sys_req <= 16'h0000;
		start(6);
		`CHK(wcnt, 26)
		`CHK(last_sp, 32'h298)
		`CHK(link_register, 32'hffffffed)
		`CHK(core_mem_model_i.mem[8'hae], 32'h20)
		`CHK(core_mem_model_i.mem[8'hbe], 32'h30)
		rd(8'h88, 32'h10);
		rd(8'h8c, 32'h40);
		done(32'hffffffed);
		start(4);
		done(32'hffffffed);
		wait_resume();
		`CHK(rcnt, 26)
	endtask : t_late

	// ==============================
	// Main sequence
	initial begin
		int k;
		rst_n = 1'b0;
		{reg_wr, reg_rd, fp_active, psp_sel, handler_done} = 5'h0;
		{reg_addr, irq_pin, sys_req} = 32'h0;
		{reg_wdata, done_code, last_sp} = 96'h0;
		msp = 32'h204;
		psp = 32'h300;
		exec_delay = 3'h1;
		{fail_count, n_checks, wcnt, rcnt, mrdc} = 160'h0;
		ctx = {32'h10, 32'h11, 32'h12, 32'h13, 32'h1c, 32'h1e, 32'habc, 32'h01000000};
		w = '{32'h10, 32'h11, 32'h12, 32'h13, 32'h1c, 32'h1e, 32'habc, 32'h01000200};
		for (k = 0; k < 17; k++) fp_state[k] = 32'h20 + k;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		t_regs();
		t_basic();
		t_order();
		t_group();
		t_mask();
		t_late();
		conclude();
	end
endmodule : tb
